// ===== include/tmb_pkg.sv
// Purpose: constants and types for the three-mode 16-bit timer channel
// Assumes: AHB-Lite register access, 32-bit data
// Notes:   one channel per instance
package tmb_pkg;
	// =====================================================
	// register map (byte addresses)
	localparam logic [11:0] TMB_OFS_START = 12'h000;
	localparam logic [11:0] TMB_OFS_MODE  = 12'h004;
	localparam logic [11:0] TMB_OFS_DATA  = 12'h008;
	// =====================================================
	// mode register fields
	localparam int TMB_MODE_LSB   = 0;
	localparam int TMB_EDGE_LSB   = 2;
	localparam int TMB_WIDTH_BIT  = 4;
	localparam int TMB_CLKSEL_LSB = 6;
	localparam int TMB_OVF_BIT    = 5;
	localparam logic [7:0]  TMB_MODE_RESET = 8'h00;
	localparam logic [15:0] TMB_DATA_RESET = 16'h0000;
	localparam logic [15:0] TMB_COUNT_MAX  = 16'hffff;
	localparam logic [15:0] TMB_COUNT_ZERO = 16'h0000;
	// =====================================================
	// prescaler
	localparam logic [4:0] TMB_DIV8_LAST  = 5'h07;
	localparam logic [4:0] TMB_DIV32_LAST = 5'h1f;
	localparam logic [1:0] TMB_HRESP_OKAY = 2'h0;

	typedef enum logic [1:0] {
		TMB_TIMER,
		TMB_EVENT,
		TMB_MEASURE,
		TMB_RSVD
	} tmb_mode_type;

	typedef enum logic [1:0] {
		TMB_CLK_DIV1,
		TMB_CLK_DIV8,
		TMB_CLK_DIV32,
		TMB_CLK_SUB32
	} tmb_clksel_type;

	typedef enum logic [1:0] {
		TMB_EDGE_FALL,
		TMB_EDGE_RISE,
		TMB_EDGE_BOTH,
		TMB_EDGE_RSVD
	} tmb_edge_type;

	typedef struct packed {
		logic [11:0] addr;
		logic        write;
		logic        valid;
	} tmb_ahb_req_type;
endpackage

// ===== rtl/tmb_timer.sv
// Purpose: 16-bit timer channel with timer, event counter and measurement modes
// Assumes: single clock hclk, pin inputs synchronous to hclk, AHB-Lite slave
// Notes:   zero wait states; subclock arrives as a synchronous enable pulse
`timescale 1ns/1ns
module tmb_timer (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic      [1:0]         hresp,
	input  wire logic               subclk_tick,
	input  wire logic               channel_pulse_input_pin,
	output logic                    irq_req,
	output logic                    measure_valid
);
	import tmb_pkg::*;

	// =====================================================
	// registers
	logic            start;
	logic [7:0]      mode_reg;
	logic            ovf_flag;
	logic [15:0]     reload;
	logic [15:0]     count;
	tmb_ahb_req_type req;
	logic [4:0]      pre8;
	logic [4:0]      pre32;
	logic [4:0]      sub32;
	logic            pin_d;
	logic            first_seen;
	logic            start_d;

	tmb_mode_type   mode;
	tmb_clksel_type clksel;
	tmb_edge_type   edge_sel;
	logic           width_meas;
	logic           tick;
	logic           rise;
	logic           fall;
	logic           eff_edge;
	logic           wr_start;
	logic           wr_mode;
	logic           wr_data;
	logic           cnt_en;
	logic           underflow;
	logic           overflow;
	logic           cap_edge;
	logic [15:0]    next_count;
	logic [15:0]    next_reload;

	assign mode       = tmb_mode_type'(mode_reg[TMB_MODE_LSB +: 2]);
	assign clksel     = tmb_clksel_type'(mode_reg[TMB_CLKSEL_LSB +: 2]);
	assign edge_sel   = tmb_edge_type'(mode_reg[TMB_EDGE_LSB +: 2]);
	assign width_meas = mode_reg[TMB_WIDTH_BIT];

	// =====================================================
	// helpers
	// address match on the decoded low bits
	function automatic logic reg_hit(
		input logic [11:0] addr,
		input logic [11:0] ofs
	);
		return addr == ofs;
	endfunction

	// word returned for a read of one register
	function automatic logic [31:0] read_word(
		input logic [11:0]  addr,
		input logic         run,
		input logic [7:0]   mreg,
		input logic         ovf,
		input tmb_mode_type md,
		input logic [15:0]  rld,
		input logic [15:0]  cnt
	);
		logic [31:0] word;
		word = 32'h0000_0000;
		if (reg_hit(addr, TMB_OFS_START)) begin
			word = {31'h0000_0000, run};
		end else if (reg_hit(addr, TMB_OFS_MODE)) begin
			word = {24'h00_0000, mreg[7:6], ovf, mreg[4:0]};
		end else if (reg_hit(addr, TMB_OFS_DATA)) begin
			if (md == TMB_MEASURE) begin
				word = {16'h0000, rld};
			end else begin
				word = {16'h0000, cnt};
			end
		end
		return word;
	endfunction

	// count enable from the selected prescaler tap
	function automatic logic tap_tick(
		input tmb_clksel_type sel,
		input logic [4:0]     p8,
		input logic [4:0]     p32,
		input logic [4:0]     s32,
		input logic           sub
	);
		logic due;
		due = 1'b1;
		case (sel)
			TMB_CLK_DIV1:  due = 1'b1;
			TMB_CLK_DIV8:  due = (p8 == TMB_DIV8_LAST);
			TMB_CLK_DIV32: due = (p32 == TMB_DIV32_LAST);
			default:       due = sub && (s32 == TMB_DIV32_LAST);
		endcase
		return due;
	endfunction

	// effective edge for the current mode and edge settings
	function automatic logic pick_edge(
		input tmb_mode_type md,
		input tmb_edge_type esel,
		input logic         wide,
		input logic         up,
		input logic         down
	);
		logic hit;
		hit = 1'b0;
		if (md == TMB_MEASURE) begin
			// period: one polarity picked by edge bit 0; width: both edges
			if (wide) begin
				hit = up || down;
			end else begin
				hit = esel[0] ? up : down;
			end
		end else begin
			case (esel)
				TMB_EDGE_RISE: hit = up;
				TMB_EDGE_FALL: hit = down;
				default:       hit = up || down;
			endcase
		end
		return hit;
	endfunction

	// =====================================================
	// bus slave
	assign wr_start = req.valid && req.write && reg_hit(req.addr, TMB_OFS_START);
	assign wr_mode  = req.valid && req.write && reg_hit(req.addr, TMB_OFS_MODE);
	assign wr_data  = req.valid && req.write && reg_hit(req.addr, TMB_OFS_DATA);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req <= '0;
		end else if (hready) begin
			req.valid <= hsel && htrans[1];
			req.write <= hwrite;
			req.addr  <= haddr[11:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= TMB_HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= TMB_HRESP_OKAY;
		end
	end

	// read data registered from the read's own address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			// unmapped places read as zero
			hrdata <= read_word(haddr[11:0], start, mode_reg, ovf_flag, mode, reload, count);
		end
	end

	// =====================================================
	// control registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			start <= 1'b0;
		end else if (wr_start) begin
			start <= hwdata[0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_reg <= TMB_MODE_RESET;
		end else if (wr_mode) begin
			mode_reg <= hwdata[7:0];
		end
	end

	// =====================================================
	// prescaler taps
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre8  <= 5'h00;
			pre32 <= 5'h00;
			sub32 <= 5'h00;
		end else begin
			pre8  <= (pre8 == TMB_DIV8_LAST) ? 5'h00 : pre8 + 5'h01;
			pre32 <= pre32 + 5'h01;
			if (subclk_tick) begin
				sub32 <= sub32 + 5'h01;
			end
		end
	end

	// taps run free, so the first tick after start may come early by up to one period
	assign tick = tap_tick(clksel, pre8, pre32, sub32, subclk_tick);

	// =====================================================
	// input edge detect
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_d <= 1'b0;
		end else begin
			pin_d <= channel_pulse_input_pin;
		end
	end

	assign rise = channel_pulse_input_pin && !pin_d;
	assign fall = !channel_pulse_input_pin && pin_d;

	assign eff_edge = pick_edge(mode, edge_sel, width_meas, rise, fall);

	// =====================================================
	// counter
	always_comb begin
		if (mode == TMB_EVENT) begin
			cnt_en = start && eff_edge;
		end else begin
			cnt_en = start && tick;
		end
	end

	assign underflow = (mode != TMB_MEASURE) && cnt_en && (count == TMB_COUNT_ZERO);
	assign cap_edge  = (mode == TMB_MEASURE) && start && eff_edge;
	assign overflow  = (mode == TMB_MEASURE) && start && tick && !eff_edge
		&& (count == TMB_COUNT_MAX);

	// a stopped write wins over nothing else, since no count runs while stopped
	always_comb begin
		next_count = count;
		if (mode == TMB_MEASURE) begin
			if (cap_edge) begin
				next_count = TMB_COUNT_ZERO;
			end else if (start && tick) begin
				next_count = count + 16'h0001;
			end
		end else if (wr_data && !start) begin
			next_count = hwdata[15:0];
		end else if (underflow) begin
			next_count = reload;
		end else if (cnt_en) begin
			next_count = count - 16'h0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= TMB_DATA_RESET;
		end else begin
			count <= next_count;
		end
	end

	// measurement owns the reload register; bus writes are dropped there
	always_comb begin
		next_reload = reload;
		if (mode == TMB_MEASURE) begin
			if (cap_edge) begin
				next_reload = count;
			end
		end else if (wr_data) begin
			next_reload = hwdata[15:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reload <= TMB_DATA_RESET;
		end else begin
			reload <= next_reload;
		end
	end

	// =====================================================
	// first-edge tracking and validity
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			start_d <= 1'b0;
		end else begin
			start_d <= start;
		end
	end

	// cleared while stopped, so an edge in the very first running cycle still counts
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			first_seen <= 1'b0;
		end else if (!start) begin
			first_seen <= 1'b0;
		end else if (cap_edge) begin
			first_seen <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			measure_valid <= 1'b0;
		end else if (!start || mode != TMB_MEASURE) begin
			measure_valid <= 1'b0;
		end else if (cap_edge && first_seen) begin
			measure_valid <= 1'b1;
		end
	end

	// =====================================================
	// overflow flag and interrupt request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ovf_flag <= 1'b0;
		end else if (overflow) begin
			ovf_flag <= 1'b1;
		end else if (wr_mode && start) begin
			ovf_flag <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_req <= 1'b0;
		end else begin
			irq_req <= underflow
				|| (cap_edge && first_seen && start_d)
				|| overflow;
		end
	end
endmodule

// ===== sim/tmb_timer_chk.sv
// Purpose: port-level assertions for the timer channel
// Assumes: one clock domain; bus writes decoded from the ports
// Notes:   shadows start, mode and reload from bus writes
`timescale 1ns/1ns
module tmb_timer_chk
	import tmb_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [1:0]  hresp,
	input wire logic        channel_pulse_input_pin,
	input wire logic        irq_req,
	input wire logic        measure_valid
);
	logic        wp, start_q, pin_d, clean, eff, wr, pin;
	logic [11:0] wa;
	logic [7:0]  mode_q;
	logic [15:0] rld_q;
	logic [16:0] gap;
	logic [1:0]  ecnt;
	assign pin = channel_pulse_input_pin;
	assign wr = hready && wp;
	assign eff = start_q && mode_q[1:0] == 2'h2 && (mode_q[4] ? pin != pin_d :
		mode_q[2] ? pin && !pin_d : !pin && pin_d);
	// ====
	// shadow registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp <= 1'b0;
			wa <= '0;
			start_q <= 1'b0;
			mode_q <= '0;
			rld_q <= '0;
		end else begin
			if (hready) begin
				wp <= hsel && htrans[1] && hwrite;
				wa <= haddr[11:0];
			end
			if (wr && wa == TMB_OFS_START) start_q <= hwdata[0];
			if (wr && wa == TMB_OFS_MODE) mode_q <= hwdata[7:0];
			if (wr && wa == TMB_OFS_DATA && mode_q[1:0] != 2'h2) rld_q <= hwdata[15:0];
		end
	end
	// edges seen since start, saturating
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_d <= 1'b0;
			ecnt <= '0;
		end else begin
			pin_d <= pin;
			if (!start_q) ecnt <= '0;
			else if (eff && ecnt != 2'h3) ecnt <= ecnt + 2'h1;
		end
	end
	// cycles between requests; clean while no write came between
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gap <= '0;
			clean <= 1'b0;
		end else begin
			gap <= irq_req ? 17'h0_0001 : gap + 17'h0_0001;
			if (wr) clean <= 1'b0;
			else if (irq_req) clean <= 1'b1;
		end
	end
	// ====
	// assertions
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_first_edge;
		eff && ecnt == 2'h0;
	endsequence
	sequence s_later_edge;
		eff && ecnt != 2'h0;
	endsequence
	a_ready_high: assert property (hreadyout) else $error("ready low");
	a_resp_okay: assert property (hresp == TMB_HRESP_OKAY) else $error("resp not okay");
	a_reset_quiet: assert property ($rose(hresetn) |-> !irq_req && !measure_valid)
		else $error("outputs active after reset");
	a_irq_needs_run: assert property (irq_req |-> start_q || $past(start_q) ||
		$past(start_q, 2)) else $error("request while stopped");
	a_timer_period: assert property (irq_req && clean && mode_q == 8'h00 |->
		gap == {1'b0, rld_q} + 17'h0_0001) else $error("timer period wrong");
	a_first_quiet: assert property (s_first_edge |=> !irq_req [*3])
		else $error("request on first edge");
	a_edge_irq: assert property (s_later_edge |-> ##[1:3] irq_req)
		else $error("no request on edge");
	a_valid_second: assert property (eff && ecnt == 2'h1 |-> ##[1:3] measure_valid)
		else $error("capture not valid");
endmodule

bind tmb_timer tmb_timer_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req), .measure_valid(measure_valid),
	.channel_pulse_input_pin(channel_pulse_input_pin));

// ===== sim/tmb_pulse_src.sv
// Purpose: external pulse source for the channel input pin
// Assumes: pin sampled on hclk
// Notes:   pulses start and end low
`timescale 1ns/1ns
module tmb_pulse_src (
	input wire logic hclk,
	output logic     pin
);
	initial pin = 1'b0;
	// n whole pulses, each level held half clocks
	task automatic pulses(input int n, input int half);
		for (int i = 0; i < 2 * n; i++) begin
			@(posedge hclk);
			pin <= ~pin;
			repeat (half - 1) @(posedge hclk);
		end
	endtask
endmodule

// ===== sim/timer_b_multimode_test.sv
// Purpose: self-checking bench for the timer channel
// Assumes: zero-wait bus slave; pin driven by the pulse model
// Notes:   overflow run takes about 66k cycles
`timescale 1ns/1ns
module timer_b_multimode_test;
	import tmb_pkg::*;
	typedef struct {logic [7:0] md; logic [15:0] rl; int np, nc, lo, hi;} tmb_row_type;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sub = 0;
	logic [1:0]  htrans = '0, hresp;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
	logic        hreadyout, pin, irq_req, measure_valid;
	int          num_errors, compares, cyc, nirq, base;
	tmb_row_type rows [8] = '{'{8'h01, 16'h0010, 3, 0, 13, 13}, '{8'h05, 16'h0010, 3, 0, 13, 13},
		'{8'h09, 16'h0010, 3, 0, 10, 10}, '{8'h0d, 16'h0010, 3, 0, 10, 10},
		'{8'h00, 16'h0004, 0, 100, 20, 22}, '{8'h40, 16'h0001, 0, 160, 9, 11},
		'{8'h80, 16'h0000, 0, 320, 9, 11}, '{8'hc0, 16'h0000, 0, 640, 9, 11}};
	tmb_timer u_tmb_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .subclk_tick(sub),
		.channel_pulse_input_pin(pin), .irq_req(irq_req), .measure_valid(measure_valid));
	tmb_pulse_src u_tmb_pulse_src (.hclk(hclk), .pin(pin));
	always #5 hclk = ~hclk;
	always @(posedge hclk) begin
		sub <= ~sub;
		cyc <= cyc + 1;
		if (irq_req === 1'b1) nirq <= nirq + 1;
		if (cyc == 90000) begin
			num_errors++;
			end_of_test;
		end
	end
	// ====
	// bus and checking tasks
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0_0000, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		compares++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			num_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, got, lo);
		end
	endtask
	task automatic end_of_test;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ====
	// sequence
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (rows[i]) begin
			xfer(1, TMB_OFS_START, '0);
			xfer(1, TMB_OFS_MODE, {24'h00_0000, rows[i].md});
			xfer(1, TMB_OFS_DATA, {16'h0000, rows[i].rl});
			base = nirq;
			xfer(1, TMB_OFS_START, 32'h0000_0001);
			if (rows[i].np > 0) u_tmb_pulse_src.pulses(rows[i].np, 2);
			else repeat (rows[i].nc) @(posedge hclk);
			repeat (3) @(posedge hclk);
			xfer(1, TMB_OFS_START, '0);
			xfer(0, TMB_OFS_DATA, '0);
			if (rows[i].np > 0) chk(r, rows[i].lo, rows[i].hi);
			else chk(nirq - base, rows[i].lo, rows[i].hi);
		end
		// write while running, then underflow reload
		xfer(1, TMB_OFS_MODE, 32'h0000_0001);
		xfer(1, TMB_OFS_DATA, 32'h0000_0010);
		xfer(1, TMB_OFS_START, 32'h0000_0001);
		xfer(1, TMB_OFS_DATA, 32'h0000_0003);
		xfer(0, TMB_OFS_DATA, '0);
		chk(r, 32'h0000_0010, 32'h0000_0010);
		base = nirq;
		u_tmb_pulse_src.pulses(17, 2);
		repeat (3) @(posedge hclk);
		xfer(0, TMB_OFS_DATA, '0);
		chk(r, 3, 3);
		chk(nirq - base, 1, 1);
		// period then width measurement
		xfer(1, TMB_OFS_START, '0);
		xfer(1, TMB_OFS_MODE, 32'h0000_0006);
		base = nirq;
		xfer(1, TMB_OFS_START, 32'h0000_0001);
		u_tmb_pulse_src.pulses(4, 10);
		repeat (3) @(posedge hclk);
		chk(nirq - base, 3, 3);
		chk(measure_valid, 1, 1);
		xfer(1, TMB_OFS_DATA, 32'h0000_1234);
		xfer(0, TMB_OFS_DATA, '0);
		chk(r, 19, 20);
		xfer(1, TMB_OFS_START, '0);
		xfer(1, TMB_OFS_MODE, 32'h0000_0012);
		xfer(1, TMB_OFS_START, 32'h0000_0001);
		u_tmb_pulse_src.pulses(3, 10);
		xfer(0, TMB_OFS_DATA, '0);
		chk(r, 9, 10);
		// overflow with no edges, then clear by mode write
		xfer(1, TMB_OFS_START, '0);
		xfer(1, TMB_OFS_MODE, 32'h0000_0002);
		base = nirq;
		xfer(1, TMB_OFS_START, 32'h0000_0001);
		repeat (65545) @(posedge hclk);
		xfer(0, TMB_OFS_MODE, '0);
		chk(r[TMB_OVF_BIT], 1, 1);
		chk(nirq - base, 1, 1);
		xfer(1, TMB_OFS_MODE, 32'h0000_0002);
		xfer(0, TMB_OFS_MODE, '0);
		chk(r[TMB_OVF_BIT], 0, 0);
		// reset in mid-run, reset values, unmapped place
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		xfer(0, TMB_OFS_MODE, '0);
		chk(r, TMB_MODE_RESET, TMB_MODE_RESET);
		xfer(0, TMB_OFS_DATA, '0);
		chk(r, TMB_DATA_RESET, TMB_DATA_RESET);
		xfer(1, 12'h00c, 32'h0000_ffff);
		xfer(0, 12'h00c, '0);
		chk(r, 0, 0);
		end_of_test;
	end
endmodule
